// >>> common/jk_pair_pkg.sv
package jk_pair_pkg;

  // Number of independent storage cells
  localparam int unsigned NUM_CELLS = 2;

  // Output values after the synchronous reset
  localparam logic Q_RST  = 1'b0;
  localparam logic QN_RST = 1'b1;

  // Last-seen cell clock level after reset; high avoids a false edge
  localparam logic CELL_CLK_PREV_RST = 1'b1;

  // Edge action selected by {j, k_n}
  typedef enum logic [1:0] {
    ACT_CLEAR  = 2'b00,
    ACT_HOLD   = 2'b01,
    ACT_TOGGLE = 2'b10,
    ACT_SET    = 2'b11
  } jk_act_e;

  // Inputs of one cell, all driven by the surrounding logic
  typedef struct packed {
    logic cell_clk;
    logic preset_n;
    logic async_reset_n;
    logic j;
    logic k_n;
  } cell_in_s;

  // Output pair of one cell
  typedef struct packed {
    logic q;
    logic q_n;
  } cell_out_s;

endpackage

// >>> design/rise_detect.sv
`timescale 1ns/1ps

module rise_detect
  import jk_pair_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic level_i,
  output logic      rise_o
);

  logic prev_r;

  // Remember the level seen at the last enabled clock
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      prev_r <= CELL_CLK_PREV_RST;
    end
    else if (ce_i)
    begin
      prev_r <= level_i;
    end
  end

  // Low-to-high change since the last enabled clock
  assign rise_o = level_i & ~prev_r;

endmodule

// >>> design/dual_jk_edge_flip_flop.sv
`timescale 1ns/1ps

// Summary of operation
// - Two cells are built, each with its own clock, preset, reset, J, inverted-K and output pair.
// - Preset low alone drives the outputs to high/low and reset low alone drives them to low/high, ignoring cell clock, J and inverted-K.
// - Preset and reset both low drive both outputs high, a state dropped once either control goes high.
// - With both controls high the true output changes only at a rising edge of the cell clock.
// - At that edge J/inverted-K of low/low clears, high/low toggles, low/high holds and high/high sets.
// - Changes on J or inverted-K between rising edges leave the outputs as they were.

module dual_jk_edge_flip_flop
  import jk_pair_pkg::*;
(
  input  wire logic     mclk_i,
  input  wire logic     rst_n_i,
  input  wire logic     ce_i,
  input  wire cell_in_s cell_i [NUM_CELLS],
  output cell_out_s     cell_o [NUM_CELLS]
);

  ////////////////////////////////////////////////////////////////////////////////
  // Per-cell storage
  ////////////////////////////////////////////////////////////////////////////////

  logic q_r    [NUM_CELLS];
  logic qn_r   [NUM_CELLS];
  logic rise_w [NUM_CELLS];

  // One independent slice per cell, sharing only mclk_i, rst_n_i and ce_i
  for (genvar g = 0; g < NUM_CELLS; g++)
  begin : g_cell

    jk_act_e act_w;

    // Edge detect on this cell's own clock pin
    rise_detect u_rise (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .ce_i    (ce_i),
      .level_i (cell_i[g].cell_clk),
      .rise_o  (rise_w[g])
    );

    // Edge action from the data pins
    assign act_w = jk_act_e'({cell_i[g].j, cell_i[g].k_n});

    // Output pair update; asynchronous controls win over the clock path
    always_ff @(posedge mclk_i)
    begin
      if (!rst_n_i)
      begin
        q_r[g]  <= Q_RST;
        qn_r[g] <= QN_RST;
      end
      else if (ce_i)
      begin
        if (!cell_i[g].preset_n && !cell_i[g].async_reset_n)
        begin
          q_r[g]  <= 1'b1;
          qn_r[g] <= 1'b1;
        end
        else if (!cell_i[g].preset_n)
        begin
          q_r[g]  <= 1'b1;
          qn_r[g] <= 1'b0;
        end
        else if (!cell_i[g].async_reset_n)
        begin
          q_r[g]  <= 1'b0;
          qn_r[g] <= 1'b1;
        end
        else if (rise_w[g])
        begin
          unique case (act_w)
            ACT_CLEAR:
            begin
              q_r[g]  <= 1'b0;
              qn_r[g] <= 1'b1;
            end
            ACT_TOGGLE:
            begin
              q_r[g]  <= ~q_r[g];
              qn_r[g] <= q_r[g];
            end
            ACT_HOLD:
            begin
              q_r[g]  <= q_r[g];
              qn_r[g] <= ~q_r[g];
            end
            ACT_SET:
            begin
              q_r[g]  <= 1'b1;
              qn_r[g] <= 1'b0;
            end
          endcase
        end
        else
        begin
          // No edge: keep the true output, leave the both-high state
          q_r[g]  <= q_r[g];
          qn_r[g] <= ~q_r[g];
        end
      end
    end

    // Outputs straight from the pair registers
    assign cell_o[g] = cell_out_s'{q   : q_r[g],
                                   q_n : qn_r[g]};

    ////////////////////////////////////////////////////////////////////////////
    // Checks on this cell
    ////////////////////////////////////////////////////////////////////////////

    // Preset alone forces high/low on the next clock
    a_preset_forces: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && !cell_i[g].preset_n && cell_i[g].async_reset_n)
      |=> (q_r[g] && !qn_r[g]))
      else $error("preset did not force q high");

    // Reset alone forces low/high on the next clock
    a_reset_forces: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && cell_i[g].preset_n && !cell_i[g].async_reset_n)
      |=> (!q_r[g] && qn_r[g]))
      else $error("reset did not force q low");

    // Both controls low give both outputs high
    a_both_low: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && !cell_i[g].preset_n && !cell_i[g].async_reset_n)
      |=> (q_r[g] && qn_r[g]))
      else $error("both controls low did not raise both outputs");

    // No clock edge, controls high: true output stays
    a_no_edge_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && cell_i[g].preset_n && cell_i[g].async_reset_n && !rise_w[g])
      |=> (q_r[g] == $past(q_r[g])))
      else $error("output changed without a clock edge");

    // Data moving between edges does not disturb the pair
    a_data_between: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && cell_i[g].preset_n && cell_i[g].async_reset_n && !rise_w[g]
       && (q_r[g] != qn_r[g]) && ($changed(cell_i[g].j) || $changed(cell_i[g].k_n)))
      |=> ($stable(q_r[g]) && $stable(qn_r[g])))
      else $error("data change between edges moved outputs");

    // Clear action at an edge
    a_edge_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && cell_i[g].preset_n && cell_i[g].async_reset_n && rise_w[g]
       && !cell_i[g].j && !cell_i[g].k_n)
      |=> (!q_r[g] && qn_r[g]))
      else $error("edge with J and inverted K low did not clear");

    // Toggle action at an edge
    a_edge_toggle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && cell_i[g].preset_n && cell_i[g].async_reset_n && rise_w[g]
       && cell_i[g].j && !cell_i[g].k_n)
      |=> (q_r[g] == !$past(q_r[g])))
      else $error("edge with J high and inverted K low did not toggle");

    // Hold action at an edge
    a_edge_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && cell_i[g].preset_n && cell_i[g].async_reset_n && rise_w[g]
       && !cell_i[g].j && cell_i[g].k_n)
      |=> (q_r[g] == $past(q_r[g])))
      else $error("edge with J low and inverted K high did not hold");

    // Set action at an edge
    a_edge_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && cell_i[g].preset_n && cell_i[g].async_reset_n && rise_w[g]
       && cell_i[g].j && cell_i[g].k_n)
      |=> (q_r[g] && !qn_r[g]))
      else $error("edge with J and inverted K high did not set");

    // Complementary pair whenever a control is high
    a_pair_compl: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && (cell_i[g].preset_n || cell_i[g].async_reset_n))
      |=> (q_r[g] != qn_r[g]))
      else $error("outputs not complementary");

    // Enable low freezes the pair
    a_ce_freeze: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (!ce_i) |=> ($stable(q_r[g]) && $stable(qn_r[g])))
      else $error("outputs moved with enable low");

  end

endmodule

// >>> sim/board_drive.sv
`timescale 1ns/1ps

// Board logic in front of both cells: raw, toggle or D wiring
module board_drive
  import jk_pair_pkg::*;
(
  input  wire logic [1:0] mode_i [NUM_CELLS],
  input  wire logic       d_i    [NUM_CELLS],
  input  wire cell_in_s   raw_i  [NUM_CELLS],
  output cell_in_s        cell_o [NUM_CELLS]
);
  // Mode 1 ties J high and inverted-K low, mode 2 ties both to one line
  always_comb
  begin
    for (int c = 0; c < NUM_CELLS; c++)
    begin
      cell_o[c] = raw_i[c];
      if (mode_i[c] == 2'h1)
        {cell_o[c].j, cell_o[c].k_n} = 2'h2;
      if (mode_i[c] == 2'h2)
        {cell_o[c].j, cell_o[c].k_n} = {2{d_i[c]}};
    end
  end
endmodule

// >>> sim/dual_jk_edge_flip_flop_tb_top.sv
`timescale 1ns/1ps

module dual_jk_edge_flip_flop_tb_top
  import jk_pair_pkg::*;
;
  logic       mclk_i      = 1'b0;
  logic       rst_n_i     = 1'b0;
  logic       ce_i        = 1'b1;
  logic [1:0] mode        [NUM_CELLS];
  logic       d           [NUM_CELLS];
  cell_in_s   raw         [NUM_CELLS];
  cell_in_s   cin         [NUM_CELLS];
  cell_out_s  cout        [NUM_CELLS];
  int         n_mismatch  = 0;
  int         comparisons = 0;
  int         cycles      = 0;
  // Rows: cell_clk, preset_n, async_reset_n, j, k_n, then q, q_n
  logic [6:0] rows [11] = '{7'h12, 7'h21, 7'h03, 7'h36, 7'h71, 7'h7a, 7'h79, 7'h7e, 7'h76, 7'h32, 7'h71};

  board_drive drv (
    .mode_i (mode),
    .d_i    (d),
    .raw_i  (raw),
    .cell_o (cin)
  );

  dual_jk_edge_flip_flop dut (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .cell_i  (cin),
    .cell_o  (cout)
  );

  ////////////////////////////////////////
  // Clock and hang guard
  always #2 mclk_i = ~mclk_i;

  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  // Compare one output pair
  task automatic check(input string name, input cell_out_s seen, input cell_out_s exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    mode = '{2'h0, 2'h0};
    d = '{1'b0, 1'b0};
    raw = '{5'h0c, 5'h0c};
    repeat (16) @(negedge mclk_i);
    rst_n_i = 1'b1;
    check("reset value", cout[0], 2'h1);
    raw[1] = 5'h04;
    // Table rows on cell 0, cell 1 held preset
    foreach (rows[i])
    begin
      @(negedge mclk_i);
      raw[0] = {1'b0, rows[i][5:2]};
      @(negedge mclk_i);
      raw[0].cell_clk = rows[i][6];
      @(negedge mclk_i);
      check("cell0 row", cout[0], rows[i][1:0]);
      check("cell1 preset", cout[1], 2'h2);
    end
    // Cell 0 as D stage, cell 1 as toggle stage
    raw[1] = 5'h0c;
    mode = '{2'h2, 2'h1};
    for (int i = 0; i < 3; i++)
    begin
      d[0] = ~i[0];
      raw[0].cell_clk = 1'b0;
      raw[1].cell_clk = 1'b0;
      @(negedge mclk_i);
      raw[0].cell_clk = 1'b1;
      raw[1].cell_clk = 1'b1;
      @(negedge mclk_i);
      check("d stage", cout[0], {~i[0], i[0]});
      check("toggle", cout[1], {i[0], ~i[0]});
    end
    // J and inverted-K moving with the cell clock steady high
    mode[0] = 2'h0;
    for (int v = 0; v < 4; v++)
    begin
      raw[0] = {3'h7, v[1:0]};
      @(negedge mclk_i);
      check("between edges", cout[0], 2'h2);
    end
    // Clock enable low freezes a pending preset
    ce_i = 1'b0;
    raw[1].preset_n = 1'b0;
    repeat (2) @(negedge mclk_i);
    check("frozen", cout[1], 2'h1);
    ce_i = 1'b1;
    @(negedge mclk_i);
    check("preset", cout[1], 2'h2);
    // Second reset in mid-run
    rst_n_i = 1'b0;
    @(negedge mclk_i);
    check("mid reset", cout[1], 2'h1);
    rst_n_i = 1'b1;
    // Pending preset acts again; cell 0 clock already high at release is no edge
    @(negedge mclk_i);
    check("preset after reset", cout[1], 2'h2);
    check("no edge after reset", cout[0], 2'h1);
    finish_test();
  end
endmodule
